// *** core/bus_status_pkg.sv ***
// Package for the bus event status register block.
// Assumes a single bus clock domain with synchronous active-low reset.
package bus_status_pkg;

    // Status register field positions
    localparam int INT_STAT_BIT    = 3;
    localparam int CAP_LIST_BIT    = 4;
    localparam int FAST66_BIT      = 5;
    localparam int FB2B_BIT        = 7;
    localparam int MDPERR_BIT      = 8;
    localparam int DEVSEL_LO_BIT   = 9;
    localparam int DEVSEL_HI_BIT   = 10;
    localparam int SIG_TABORT_BIT  = 11;
    localparam int RCV_TABORT_BIT  = 12;
    localparam int RCV_MABORT_BIT  = 13;
    localparam int SIG_SERR_BIT    = 14;
    localparam int DET_PERR_BIT    = 15;

    // Command register field positions used here
    localparam int PERR_RESP_BIT   = 6;
    localparam int INT_DIS_BIT     = 10;

    // DEVSEL timing codes
    localparam logic [1:0] DEVSEL_FAST   = 2'h0;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [1:0] DEVSEL_SLOW   = 2'h2;

    // Reset values
    localparam logic [15:0] STATUS_RST  = 16'h0000;
    localparam logic [15:0] COMMAND_RST = 16'h0000;

    // Mask of the write-one-to-clear flags
    localparam logic [15:0] W1C_MASK    = 16'hf900;

    // Bus events reported by the surrounding agent, one-cycle pulses
    typedef struct packed {
        logic master_perr;
        logic sig_tabort;
        logic rcv_tabort;
        logic rcv_mabort;
        logic special_cycle;
        logic serr_driven;
        logic perr_detected;
    } bus_events_t;

    // Register access port
    typedef struct packed {
        logic        wr_stat;
        logic        wr_cmd;
        logic [15:0] wdata;
    } reg_write_t;

endpackage

// *** core/bus_event_status.sv ***
// Status register of a bus agent with the two command bits it depends on.
// Assumes event inputs are one-cycle pulses synchronous to i_mclk.
//
// Overview of operation
// - Reserved status bits read zero, ignore writes
// - Writing one clears a flag; never sets
// - Bit 3 mirrors interrupt; pin needs enable
// - Interrupt disable blocks pin only, not bit
// - Bit 4 shows capability list presence
// - Bit 5 shows 66 MHz capability
// - Bit 7 shows fast back-to-back acceptance
// - Master parity flag needs master and enable
// - Bits 9-10 encode DEVSEL class, never 11b
// - DEVSEL code is slowest non-config response
// - Bit 11 set on signalled target abort
// - Bit 12 set on received target abort
// - Bit 13 on master abort, not special
// - Both received abort flags are implemented
// - Bit 14 set whenever SERR is driven
// - Bit 15 set on any detected parity error
// - Command bit 10 disables interrupt pin
// - Command bit 6 enables parity error drive
`timescale 1ns/1ps
`default_nettype none

module bus_event_status
    import bus_status_pkg::*;
#(
    parameter logic       CAP_LIST_EN = 1'b0,
    parameter logic       FAST66_EN   = 1'b0,
    parameter logic       FB2B_EN     = 1'b0,
    parameter logic [1:0] DEVSEL_CODE = DEVSEL_MEDIUM
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire reg_write_t  i_wr,
    input  wire bus_events_t i_ev,
    input  wire logic        i_int_pending,
    output logic [15:0]      o_status,
    output logic [15:0]      o_command,
    output logic             o_int_assert,
    output logic             o_perr_drive_en
);

    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] fixed_vec;
    logic        int_q;
    logic        int_dis_q;
    logic        perr_en_q;
    logic [1:0]  devsel_safe;

    // Never report the reserved code
    assign devsel_safe = (DEVSEL_CODE == 2'h3) ? DEVSEL_SLOW
                                               : DEVSEL_CODE;

    // Read-only capability bits; o_status reads them as zero during reset
    always_comb
    begin
        fixed_vec = 16'h0000;
        fixed_vec[CAP_LIST_BIT] = CAP_LIST_EN;
        fixed_vec[FAST66_BIT] = FAST66_EN;
        fixed_vec[FB2B_BIT] = FB2B_EN;
        fixed_vec[DEVSEL_HI_BIT:DEVSEL_LO_BIT] = devsel_safe;
    end

    // Event set vector
    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[MDPERR_BIT] = i_ev.master_perr & perr_en_q;
        set_vec[SIG_TABORT_BIT] = i_ev.sig_tabort;
        set_vec[RCV_TABORT_BIT] = i_ev.rcv_tabort;
        set_vec[RCV_MABORT_BIT] = i_ev.rcv_mabort
                                  & ~i_ev.special_cycle;
        set_vec[SIG_SERR_BIT] = i_ev.serr_driven;
        set_vec[DET_PERR_BIT] = i_ev.perr_detected;
    end

    assign clr_vec = i_wr.wr_stat ? (i_wr.wdata & W1C_MASK)
                                  : 16'h0000;
    // Set wins over a simultaneous clear
    assign flags_d = ((flags_q & ~clr_vec) | set_vec) & W1C_MASK;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            flags_q   <= STATUS_RST;
            int_q     <= 1'b0;
            int_dis_q <= COMMAND_RST[INT_DIS_BIT];
            perr_en_q <= COMMAND_RST[PERR_RESP_BIT];
        end
        else
        begin
            flags_q <= flags_d;
            int_q   <= i_int_pending;
            if (i_wr.wr_cmd)
            begin
                int_dis_q <= i_wr.wdata[INT_DIS_BIT];
                perr_en_q <= i_wr.wdata[PERR_RESP_BIT];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_status        <= STATUS_RST;
            o_command       <= COMMAND_RST;
            o_int_assert    <= 1'b0;
            o_perr_drive_en <= 1'b0;
        end
        else
        begin
            o_status <= flags_d | fixed_vec
                        | ({15'h0000, i_int_pending} << INT_STAT_BIT);
            o_command <= 16'h0000;
            o_command[INT_DIS_BIT] <= i_wr.wr_cmd ? i_wr.wdata[INT_DIS_BIT]
                                                  : int_dis_q;
            o_command[PERR_RESP_BIT] <= i_wr.wr_cmd ? i_wr.wdata[PERR_RESP_BIT]
                                                    : perr_en_q;
            o_int_assert <= int_q & ~int_dis_q;
            o_perr_drive_en <= perr_en_q;
        end
    end

endmodule

`default_nettype wire

// *** tb/bus_event_status_assertions.sv ***
// Port checker for the bus event status register.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bus_event_status_assertions
    import bus_status_pkg::*;
#(parameter logic [1:0] DEVSEL_CODE = DEVSEL_MEDIUM)
(
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire reg_write_t  i_wr,
    input wire bus_events_t i_ev,
    input wire logic        i_int_pending,
    input wire logic [15:0] o_status,
    input wire logic [15:0] o_command,
    input wire logic        o_int_assert
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    chk_rsvd_zero: assert property ({o_status[6], o_status[2:0]} == 4'h0)
        else $error("reserved bit set");
    chk_devsel_class: assert property ($past(i_rst_n) |-> o_status[10:9] == DEVSEL_CODE)
        else $error("bad devsel code");
    chk_flag_reset: assert property (!$past(i_rst_n) |-> o_status == 16'h0000)
        else $error("status not cleared");
    chk_tabort_sets: assert property ($past(i_rst_n && i_ev.sig_tabort) |-> o_status[11])
        else $error("abort flag not set");
    chk_one_clears: assert property ($past(i_rst_n && i_wr.wr_stat && i_wr.wdata[14]
        && !i_ev.serr_driven) |-> !o_status[14])
        else $error("flag not cleared");
    chk_mperr_gate: assert property ($rose(o_status[8]) |-> $past(i_ev.master_perr && o_command[6]))
        else $error("bit8 set wrongly");
    chk_mabort_rule: assert property ($rose(o_status[13]) |-> $past(!i_ev.special_cycle))
        else $error("bit13 set wrongly");
    chk_int_gate: assert property (o_int_assert |-> $past(i_int_pending, 2) && !$past(o_command[10]))
        else $error("pin asserted wrongly");
endmodule
bind bus_event_status bus_event_status_assertions #(.DEVSEL_CODE(DEVSEL_CODE)) u_chk (.*);
`default_nettype wire

// *** tb/bus_agent_model.sv ***
// Far-side agent: turns bench requests into event pulses.
// Assumes the bench sets a request for one cycle.
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model
    import bus_status_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire bus_events_t i_req,
    output var bus_events_t  o_ev
);
    initial o_ev = '0;
    always @(negedge i_mclk) o_ev <= i_req;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Bench for the bus event status register.
// Assumes default parameters: medium DEVSEL, no options.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bus_status_pkg::*;
;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    reg_write_t  wr = '0;
    bus_events_t rq = '0;
    bus_events_t ev;
    logic        pend = 1'b0;
    logic [15:0] st, cmd;
    logic        int_o;
    logic        pdrv;
    int          n_mismatch = 0;
    int          checks_done = 0;
    logic [6:0]  evs [5] = '{7'h20, 7'h10, 7'h08, 7'h02, 7'h01};
    localparam logic [15:0] FIX = {5'h0, DEVSEL_MEDIUM, 9'h000};
    bus_agent_model u_bus_agent_model (.i_mclk(i_mclk), .i_req(rq), .o_ev(ev));
    bus_event_status u_bus_event_status (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_wr(wr), .i_ev(ev), .i_int_pending(pend), .o_status(st),
        .o_command(cmd), .o_int_assert(int_o), .o_perr_drive_en(pdrv));
    task automatic chk(string w, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask
    task automatic wr_reg(logic c, logic [15:0] d);
        @(negedge i_mclk);
        wr <= '{!c, c, d};
        @(negedge i_mclk);
        wr <= '0;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic fire(logic [6:0] e);
        @(negedge i_mclk);
        rq <= e;
        @(negedge i_mclk);
        rq <= '0;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial forever #12.5 i_mclk = ~i_mclk;
    initial
    begin
        repeat (6) @(negedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(negedge i_mclk);
        chk("status", FIX, st);
        wr_reg(1'b0, 16'hffff);
        chk("status", FIX, st);
        $display("reset test done");
        for (int k = 0; k < 5; k++)
        begin
            fire(evs[k]);
            wr_reg(1'b0, ~(16'h0800 << k));
            chk("flag", FIX | (16'h0800 << k), st);
            wr_reg(1'b0, 16'h0800 << k);
            chk("flag", FIX, st);
        end
        $display("event test done");
        fire(7'h0c);
        fire(7'h40);
        chk("status", FIX, st);
        wr_reg(1'b1, 16'h0040);
        fire(7'h40);
        chk("status", FIX | 16'h0100, st);
        $display("parity test done");
        pend <= 1'b1;
        repeat (3) @(negedge i_mclk);
        chk("pin", 16'h1, {15'h0, int_o});
        wr_reg(1'b1, 16'h0440);
        chk("pin", 16'h0, {15'h0, int_o});
        chk("status", FIX | 16'h0108, st);
        chk("command", 16'h0440, cmd);
        chk("perr drive", 16'h0001, {15'h0, pdrv});
        $display("interrupt test done");
        pend <= 1'b0;
        i_rst_n <= 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rst_n <= 1'b1;
        chk("status", 16'h0000, st);
        repeat (2) @(negedge i_mclk);
        chk("status", FIX, st);
        chk("command", 16'h0000, cmd);
        chk("pin", 16'h0000, {15'h0, int_o});
        chk("perr drive", 16'h0000, {15'h0, pdrv});
        $display("second reset test done");
        close_out();
    end
endmodule
`default_nettype wire
